// ==== reset_group_select_defines.svh ====
// offsets, bit positions, reset values and nanosecond timings of the reset group select block
`ifndef RESET_GROUP_SELECT_DEFINES_SVH
`define RESET_GROUP_SELECT_DEFINES_SVH

`define RGS_ADDR_W            4
`define RGS_OFF_CTRL          4'h0
`define RGS_OFF_STATE         4'h1
`define RGS_OFF_THRESH        4'h2
`define RGS_OFF_DMA           4'h3

`define RGS_BIT_GLOBAL        16
`define RGS_BIT_RX            17
`define RGS_BIT_TX            18
`define RGS_BIT_FIFO          20
`define RGS_BIT_NET           21
`define RGS_BIT_HOST          22
`define RGS_BIT_BUSY          26

`define RGS_BIT_DMA_TXPROG    0

`define RGS_THRESH_W          13
`define RGS_THRESH_RST        13'h0000

`define RGS_PULSE_NS          400
`define RGS_CLK_NS            100

`endif

// ==== reset_group_select_pkg.sv ====
// types of the reset group select block
package reset_group_select_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_DONE
	} seq_state_e;

	// which resets and groups one control write asked for
	typedef struct packed {
		logic whole;
		logic rx;
		logic tx;
		logic fifo;
		logic net;
		logic host;
	} reset_req_s;

	// clear strobes that fan out to the function groups
	typedef struct packed {
		logic tx_fifo;
		logic rx_fifo;
		logic thresh;
		logic tx_net;
		logic rx_net;
		logic tx_mac;
		logic rx_mac;
		logic tx_status;
		logic rx_mode;
		logic stats;
		logic host;
		logic tx_dma_prog;
	} group_clear_s;

endpackage : reset_group_select_pkg

// ==== reset_scope_if.sv ====
// request and clear bundle between the sequencer and the scope decoder
`timescale 1ns/100ps
interface reset_scope_if;
	reset_group_select_pkg::reset_req_s   req;
	logic                                 fire;
	reset_group_select_pkg::group_clear_s clr;

	modport seq (output req, output fire, input clr);
	modport dec (input req, input fire, output clr);
endinterface : reset_scope_if

// ==== reset_scope_decode.sv ====
// maps the latched reset sources and group selects onto group clear strobes
`timescale 1ns/100ps
module reset_scope_decode (
	reset_scope_if.dec scope
);
	reset_group_select_pkg::group_clear_s c;
	logic                                 do_tx;
	logic                                 do_rx;

	always_comb begin
		do_tx = scope.fire & (scope.req.tx | scope.req.whole);
		do_rx = scope.fire & (scope.req.rx | scope.req.whole);
		c = '0;
		c.tx_fifo     = do_tx & scope.req.fifo;
		c.rx_fifo     = do_rx & scope.req.fifo;
		c.thresh      = (do_tx | do_rx) & scope.req.fifo;
		c.tx_net      = do_tx & scope.req.net;
		c.tx_mac      = do_tx & scope.req.net;
		c.tx_status   = do_tx & scope.req.net;
		c.rx_net      = do_rx & scope.req.net;
		c.rx_mac      = do_rx & scope.req.net;
		c.rx_mode     = do_rx & scope.req.net;
		c.stats       = do_rx & scope.req.net;
		// only the whole-device source reaches the host interface
		c.host        = scope.fire & scope.req.whole & scope.req.host;
		c.tx_dma_prog = do_tx;
	end

	assign scope.clr = c;
endmodule : reset_scope_decode

// ==== reset_group_select.sv ====
// reset group select: control register, reset sequencer and group clear outputs
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "reset_group_select_defines.svh"
// Overview of operation
// - fifo select includes fifo in resets
// - fifo select self-clears after reset
// - start threshold cleared with fifo group
// - network group split by tx/rx source
// - host select includes host in global
// - host select self-clears after reset
// - host cleared only by global reset
// - tx dma flag cleared by tx/global
// - global reset clears selected groups, self-clears
// - receive reset clears selected rx, self-clears
// - busy flag high while reset runs
module reset_group_select #(
	parameter int PULSE_CYCLES = (`RGS_PULSE_NS + `RGS_CLK_NS - 1) / `RGS_CLK_NS
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     arst_n,
	// register port
	input  wire logic [`RGS_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// transmit dma in progress set by the dma engine
	input  wire logic                     tx_dma_start,
	// group clear strobes, one per cycle of the reset pulse
	output logic                          clr_tx_fifo,
	output logic                          clr_rx_fifo,
	output logic                          clr_tx_net,
	output logic                          clr_rx_net,
	output logic                          clr_tx_mac,
	output logic                          clr_rx_mac,
	output logic                          clr_tx_status,
	output logic                          clr_rx_mode,
	output logic                          clr_stats,
	output logic                          clr_host,
	// state of owned registers
	output logic [`RGS_THRESH_W-1:0]      transmit_start_threshold,
	output logic                          transmit_dma_in_progress,
	output logic                          reset_in_progress
);

	// the pulse counter is eight bits wide
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_pulse_chk
		$error("PULSE_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		reset_group_select_pkg::seq_state_e st;
		reset_group_select_pkg::reset_req_s req;
		logic [7:0]                         cnt;
		logic [`RGS_THRESH_W-1:0]           thresh;
		logic                               dma_prog;
		logic [31:0]                        rdata;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	reset_scope_if scope ();

	reset_scope_decode u_decode (
		.scope (scope)
	);

	assign scope.req  = s_r.req;
	assign scope.fire = (s_r.st == reset_group_select_pkg::ST_PULSE);

	function automatic reset_group_select_pkg::reset_req_s take_req(input logic [31:0] d);
		reset_group_select_pkg::reset_req_s r;
		r.whole = d[`RGS_BIT_GLOBAL];
		r.rx    = d[`RGS_BIT_RX];
		r.tx    = d[`RGS_BIT_TX];
		r.fifo  = d[`RGS_BIT_FIFO];
		r.net   = d[`RGS_BIT_NET];
		r.host  = d[`RGS_BIT_HOST];
		return r;
	endfunction : take_req

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic ctl_wr;
		logic busy;
		ctl_wr = reg_wr && (reg_addr == `RGS_OFF_CTRL);
		busy   = (s_r.st != reset_group_select_pkg::ST_IDLE);
		s_nxt  = s_r;

		case (s_r.st)
			reset_group_select_pkg::ST_IDLE: begin
				// one write captures both sources and selects
				if (ctl_wr && (reg_wdata[`RGS_BIT_GLOBAL] | reg_wdata[`RGS_BIT_RX]
						| reg_wdata[`RGS_BIT_TX])) begin
					s_nxt.req = take_req(reg_wdata);
					s_nxt.cnt = PULSE_CYCLES[7:0];
					s_nxt.st  = reset_group_select_pkg::ST_PULSE;
				end
			end
			reset_group_select_pkg::ST_PULSE: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01)
					s_nxt.st = reset_group_select_pkg::ST_DONE;
			end
			reset_group_select_pkg::ST_DONE: begin
				// sources and selects all self-clear together
				s_nxt.req = '0;
				s_nxt.st  = reset_group_select_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.req = '0;
				s_nxt.st  = reset_group_select_pkg::ST_IDLE;
			end
		endcase

		// writes during a running reset are dropped for the threshold too
		if (reg_wr && (reg_addr == `RGS_OFF_THRESH) && !busy)
			s_nxt.thresh = reg_wdata[`RGS_THRESH_W-1:0];
		if (scope.clr.thresh)
			s_nxt.thresh = `RGS_THRESH_RST;

		if (tx_dma_start)
			s_nxt.dma_prog = 1'b1;
		else if (scope.clr.tx_dma_prog)
			s_nxt.dma_prog = 1'b0;

		s_nxt.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`RGS_OFF_CTRL: s_nxt.rdata[`RGS_BIT_BUSY] = busy;
				`RGS_OFF_STATE: s_nxt.rdata[1:0] = s_r.st;
				`RGS_OFF_THRESH: s_nxt.rdata[`RGS_THRESH_W-1:0] = s_r.thresh;
				`RGS_OFF_DMA: s_nxt.rdata[`RGS_BIT_DMA_TXPROG] = s_r.dma_prog;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{st: reset_group_select_pkg::ST_IDLE, req: '0, cnt: 8'h00,
				thresh: `RGS_THRESH_RST, dma_prog: 1'b0, rdata: 32'h0000_0000};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign reg_rdata                = s_r.rdata;
	assign transmit_start_threshold = s_r.thresh;
	assign transmit_dma_in_progress = s_r.dma_prog;
	assign reset_in_progress        = (s_r.st != reset_group_select_pkg::ST_IDLE);

	assign clr_tx_fifo   = scope.clr.tx_fifo;
	assign clr_rx_fifo   = scope.clr.rx_fifo;
	assign clr_tx_net    = scope.clr.tx_net;
	assign clr_rx_net    = scope.clr.rx_net;
	assign clr_tx_mac    = scope.clr.tx_mac;
	assign clr_rx_mac    = scope.clr.rx_mac;
	assign clr_tx_status = scope.clr.tx_status;
	assign clr_rx_mode   = scope.clr.rx_mode;
	assign clr_stats     = scope.clr.stats;
	assign clr_host      = scope.clr.host;

endmodule : reset_group_select

// ==== reset_group_select_properties.sv ====
// concurrent checks on the reset group select ports
`timescale 1ns/100ps
`include "reset_group_select_defines.svh"
module reset_group_select_properties #(
	parameter int PULSE_CYCLES = 4
) (
	// clock and reset
	input wire logic                     clk_sys, arst_n,
	// register port
	input wire logic [`RGS_ADDR_W-1:0]   reg_addr,
	input wire logic [31:0]              reg_wdata, reg_rdata,
	input wire logic                     reg_wr, reg_rd,
	// group clears and state
	input wire logic                     clr_tx_fifo, clr_rx_fifo, clr_tx_net, clr_rx_net,
	input wire logic                     clr_tx_mac, clr_rx_mac, clr_tx_status, clr_rx_mode,
	input wire logic                     clr_stats, clr_host,
	input wire logic [`RGS_THRESH_W-1:0] transmit_start_threshold,
	input wire logic                     transmit_dma_in_progress, reset_in_progress
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic g, r, t, f, n, h, go;
	int   busy_n;
	assign {h, n, f, t, r, g} = {reg_wdata[22:20], reg_wdata[18:16]};
	assign go = reg_wr && reg_addr == `RGS_OFF_CTRL && (g || r || t) && !reset_in_progress;
	// counter keeps the pulse length check free of long repetitions
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			busy_n <= 0;
		else
			busy_n <= reset_in_progress ? busy_n + 1 : 0;
	end
	busy_start_a: assert property (go |=> reset_in_progress)
		else $error("busy did not rise after a reset write");
	busy_len_a: assert property ($fell(reset_in_progress) |-> busy_n == PULSE_CYCLES + 1)
		else $error("busy length wrong");
	fifo_sel_a: assert property (go && f && (g || t) |=> clr_tx_fifo[*4])
		else $error("transmit fifo not cleared");
	fifo_none_a: assert property (go && !f |=> (!clr_tx_fifo && !clr_rx_fifo)[*4])
		else $error("fifo cleared without select");
	thresh_clr_a: assert property (go && f |-> ##2 transmit_start_threshold == 13'h0000)
		else $error("start threshold not cleared");
	net_rx_a: assert property (go && n && (g || r) |=>
		(clr_rx_net && clr_rx_mac && clr_rx_mode && clr_stats)[*4])
		else $error("receive network group not cleared");
	net_tx_off_a: assert property (go && n && !g && !t |=>
		!(clr_tx_net || clr_tx_mac || clr_tx_status)[*4])
		else $error("transmit network cleared by receive reset");
	host_sel_a: assert property (go && h && g |=> clr_host[*4])
		else $error("host group not cleared");
	host_only_a: assert property (go && !(h && g) |=> !clr_host[*4])
		else $error("host cleared without global and select");
	dma_clr_a: assert property ($fell(transmit_dma_in_progress) |-> $past(reset_in_progress))
		else $error("dma flag fell outside a reset");
	rd_busy_a: assert property (reg_rd && reg_addr == `RGS_OFF_CTRL |=>
		reg_rdata[`RGS_BIT_BUSY] == $past(reset_in_progress))
		else $error("busy readback wrong");
endmodule : reset_group_select_properties
bind reset_group_select reset_group_select_properties #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (.*);

// ==== reset_group_select_bench.sv ====
// self-checking bench for the reset group select block
`timescale 1ns/100ps
`include "reset_group_select_defines.svh"
module reset_group_select_bench;
	logic                     clk_sys, arst_n, reg_wr, reg_rd, tx_dma_start;
	logic [`RGS_ADDR_W-1:0]   reg_addr;
	logic [31:0]              reg_wdata, reg_rdata, d;
	logic                     clr_tx_fifo, clr_rx_fifo, clr_tx_net, clr_rx_net, clr_tx_mac;
	logic                     clr_rx_mac, clr_tx_status, clr_rx_mode, clr_stats, clr_host;
	logic [`RGS_THRESH_W-1:0] transmit_start_threshold;
	logic                     transmit_dma_in_progress, reset_in_progress;
	logic [9:0]               seen, want;
	logic                     g, r, t, f, n, h, tx, rx;
	int                       bad_count, checks;

	reset_group_select i_reset_group_select (.*);

	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// gathered on the falling edge, away from the launching edge
	always @(negedge clk_sys) seen |= {clr_tx_fifo, clr_rx_fifo, clr_tx_net, clr_rx_net,
		clr_tx_mac, clr_rx_mac, clr_tx_status, clr_rx_mode, clr_stats, clr_host};
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("bad_count %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// the poll is bounded so a stuck busy flag ends the run
	task automatic wait_idle;
		for (int i = 0; i < 20; i++) begin
			rd(`RGS_OFF_CTRL);
			if (d[`RGS_BIT_BUSY] === 1'b0)
				return;
		end
		bad_count++;
		tally_and_finish;
	endtask : wait_idle
	////////////////////////////////////////////////////////////////
	initial begin
		{arst_n, reg_wr, reg_rd, tx_dma_start} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		seen = 10'h000;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(`RGS_OFF_THRESH);
		cmp(d, 32'h0, "threshold after reset");
		rd(4'hf);
		cmp(d, 32'h0, "unmapped read");
		// selects with no source start nothing
		wr(`RGS_OFF_CTRL, 32'h0070_0000);
		rd(`RGS_OFF_CTRL);
		cmp(d, 32'h0, "no source no busy");
		// selects count up from all off, each pattern with every nonzero source combination
		for (int s = 1; s < 64; s++) begin
			if (s[2:0] == 3'h0)
				continue;
			{h, n, f, t, r, g} = s[5:0];
			tx = g | t;
			rx = g | r;
			wr(`RGS_OFF_THRESH, 32'h0000_1abc);
			@(posedge clk_sys) tx_dma_start <= 1'b1;
			@(posedge clk_sys) tx_dma_start <= 1'b0;
			seen = 10'h000;
			wr(`RGS_OFF_CTRL, {9'h0, h, n, f, 1'b0, t, r, g, 16'h0});
			rd(`RGS_OFF_CTRL);
			cmp({31'h0, d[`RGS_BIT_BUSY]}, 32'h1, "busy");
			wait_idle;
			want = {f & tx, f & rx, n & tx, n & rx, n & tx, n & rx, n & tx, n & rx, n & rx, h & g};
			cmp({22'h0, seen}, {22'h0, want}, "clears");
			rd(`RGS_OFF_THRESH);
			cmp(d, f ? 32'h0 : 32'h0000_1abc, "threshold");
			cmp({19'h0, transmit_start_threshold}, f ? 32'h0 : 32'h0000_1abc, "thresh pin");
			rd(`RGS_OFF_DMA);
			cmp(d, {31'h0, !tx}, "dma flag");
			cmp({31'h0, transmit_dma_in_progress}, {31'h0, !tx}, "dma pin");
			cmp({31'h0, reset_in_progress}, 32'h0, "busy pin");
			rd(`RGS_OFF_STATE);
			cmp(d, 32'h0, "state idle");
		end
		tally_and_finish;
	end
endmodule : reset_group_select_bench
